// file: rtl/csma_defs.svh
`ifndef CSMA_DEFS_SVH
`define CSMA_DEFS_SVH

`define CSMA_ADDR_W             10
`define CSMA_ADDR_MAC_CTL       10'h011
`define CSMA_ADDR_LONG_SP       10'h021
`define CSMA_ADDR_TURN          10'h027
`define CSMA_ADDR_STAB          10'h02e
`define CSMA_ADDR_STATUS        10'h03f

`define CSMA_MAC_CTL_RST        8'h1c
`define CSMA_LONG_SP_RST        8'h84
`define CSMA_TURN_RST           8'h50
`define CSMA_STAB_RST           8'h75

`define CSMA_SKIP_CA_BIT        7
`define CSMA_BLE_BIT            6
`define CSMA_SLOTTED_BIT        5
`define CSMA_MINBE_HI           4
`define CSMA_MINBE_LO           3
`define CSMA_MAXBF_HI           2
`define CSMA_MAXBF_LO           0
`define CSMA_MAXBF_LIMIT        3'h5
`define CSMA_LONG_HI            7
`define CSMA_LONG_LO            2
`define CSMA_RF_STAB_HI         7
`define CSMA_RF_STAB_LO         4
`define CSMA_SHORT_HI           3
`define CSMA_SHORT_LO           0
`define CSMA_TURN_HI            7
`define CSMA_TURN_LO            4
`define CSMA_ST_FAIL_BIT        0
`define CSMA_ST_DONE_BIT        1
`define CSMA_ST_BUSY_BIT        7

`define CSMA_SIFS_MAX_OCTETS    7'h12
`define CSMA_MAX_BE             3'h5
`define CSMA_BLE_MAX_BE         3'h2
`define CSMA_SLOTTED_CW         2'h2
`define CSMA_UNSLOTTED_CW       2'h1

`define CSMA_CLK_PERIOD_NS      10
`define CSMA_SYMBOL_NS          16000
`define CSMA_SYMBOL_CYCLES      ((`CSMA_SYMBOL_NS + `CSMA_CLK_PERIOD_NS - 1) / `CSMA_CLK_PERIOD_NS)
`define CSMA_PERIOD_SYMBOLS     20

`endif

// file: rtl/csma_pkg.sv
package csma_pkg;

   typedef enum logic [2:0] {
      CSMA_ST_IDLE    = 3'b000,
      CSMA_ST_BACKOFF = 3'b001,
      CSMA_ST_TURN    = 3'b010,
      CSMA_ST_TX      = 3'b011,
      CSMA_ST_ACK     = 3'b100,
      CSMA_ST_IFS     = 3'b101
   } csma_state_type;

endpackage : csma_pkg

// file: rtl/csma_period_timer.sv
`include "csma_defs.svh"

module csma_period_timer
   import csma_pkg::*;
#(
   parameter int CYCLES_PER_SYMBOL  = `CSMA_SYMBOL_CYCLES,
   parameter int SYMBOLS_PER_PERIOD = `CSMA_PERIOD_SYMBOLS
) (
   input  wire logic clk_in,
   input  wire logic reset_n_in,
   input  wire logic ce_in,
   output logic      sym_tick_out,
   output logic      period_tick_out
);

   logic [15:0] cyc_reg;
   logic [15:0] cyc_next;
   logic [7:0]  sym_reg;
   logic [7:0]  sym_next;
   logic        sym_tick_next;
   logic        period_tick_next;

   // Free running on purpose: the unslotted backoff grid owes nothing to any peer.
   always_comb begin
      cyc_next         = cyc_reg + 16'h0001;
      sym_next         = sym_reg;
      sym_tick_next    = 1'b0;
      period_tick_next = 1'b0;
      if (cyc_reg == 16'(CYCLES_PER_SYMBOL - 1)) begin
         cyc_next      = 16'h0000;
         sym_tick_next = 1'b1;
         if (sym_reg == 8'(SYMBOLS_PER_PERIOD - 1)) begin
            sym_next         = 8'h00;
            period_tick_next = 1'b1;
         end else begin
            sym_next = sym_reg + 8'h01;
         end
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cyc_reg         <= 16'h0000;
         sym_reg         <= 8'h00;
         sym_tick_out    <= 1'b0;
         period_tick_out <= 1'b0;
      end else if (ce_in) begin
         cyc_reg         <= cyc_next;
         sym_reg         <= sym_next;
         sym_tick_out    <= sym_tick_next;
         period_tick_out <= period_tick_next;
      end
   end

endmodule : csma_period_timer

// file: rtl/csma_ifs_top.sv
// Contract
// - In slotted mode every backoff period boundary follows the coordinator's slot boundary pulses.
// - In unslotted mode backoff periods come from a free-running local timer unrelated to any peer.
// - The slotted bit of the transmit-MAC control register selects unslotted (0) or slotted (1) access.
// - The battery-life-extension bit enables battery life extension during slotted access.
// - The minimum backoff exponent field takes 0 to 3, resets to 3 and seeds the backoff exponent.
// - The maximum backoff count field takes 0 to 5, resets to 4 and limits the number of backoffs.
// - After a frame of at most 18 octets the device waits the short spacing before transmitting again.
// - After a longer frame the device waits the long spacing before transmitting again.
// - When an acknowledgment is requested the spacing starts after the acknowledgment frame.
// - The short spacing is the short-spacing field plus the RF stabilisation field.
// - The long spacing is the six-bit long-spacing field plus the RF stabilisation field.
// - The turnaround time is the turnaround field plus the RF stabilisation field.
`include "csma_defs.svh"

module csma_ifs_top
   import csma_pkg::*;
#(
   parameter int CYCLES_PER_SYMBOL  = `CSMA_SYMBOL_CYCLES,
   parameter int SYMBOLS_PER_PERIOD = `CSMA_PERIOD_SYMBOLS
) (
   input  wire logic                    CLOCK_IN,
   input  wire logic                    RESET_N_IN,
   input  wire logic                    CE_IN,
   input  wire logic [`CSMA_ADDR_W-1:0] ADDR_IN,
   input  wire logic [7:0]              WR_DATA_IN,
   input  wire logic                    WR_STROBE_IN,
   input  wire logic                    RD_STROBE_IN,
   output logic      [7:0]              RD_DATA_OUT,
   input  wire logic                    TX_REQ_IN,
   input  wire logic [6:0]              TX_LEN_IN,
   input  wire logic                    TX_ACK_REQ_IN,
   input  wire logic                    CCA_CLEAR_IN,
   input  wire logic                    SLOT_BOUNDARY_IN,
   input  wire logic                    TX_END_IN,
   input  wire logic                    ACK_DONE_IN,
   output logic                         TX_START_OUT,
   output logic                         BUSY_OUT,
   output logic                         CA_FAIL_OUT,
   output logic                         TX_DONE_OUT
);

   ////////////////////////////////////////////////////////////////////////////////////////////////
   function automatic logic [6:0] csma_sum(input logic [5:0] field, input logic [3:0] stab);
      csma_sum = {1'b0, field} + {3'h0, stab};
   endfunction : csma_sum

   function automatic logic [4:0] csma_mask(input logic [2:0] be);
      csma_mask = 5'h1f >> (`CSMA_MAX_BE - be);
   endfunction : csma_mask

   ////////////////////////////////////////////////////////////////////////////////////////////////
   logic [7:0]     mac_ctl_reg;
   logic [7:0]     mac_ctl_next;
   logic [7:0]     long_sp_reg;
   logic [7:0]     long_sp_next;
   logic [3:0]     turn_reg;
   logic [3:0]     turn_next;
   logic [7:0]     stab_reg;
   logic [7:0]     stab_next;
   logic           fail_st_reg;
   logic           fail_st_next;
   logic           done_st_reg;
   logic           done_st_next;
   logic [7:0]     rd_next;
   logic [2:0]     wr_maxbf;

   csma_state_type state_reg;
   csma_state_type state_next;
   logic [2:0]     nb_reg;
   logic [2:0]     nb_next;
   logic [2:0]     be_reg;
   logic [2:0]     be_next;
   logic [1:0]     cw_reg;
   logic [1:0]     cw_next;
   logic [4:0]     cnt_reg;
   logic [4:0]     cnt_next;
   logic [6:0]     sym_cnt_reg;
   logic [6:0]     sym_cnt_next;
   logic [6:0]     len_reg;
   logic [6:0]     len_next;
   logic           ack_reg;
   logic           ack_next;
   logic [15:0]    lfsr_reg;
   logic [15:0]    lfsr_next;
   logic           start_next;
   logic           fail_next;
   logic           done_next;
   logic           busy_next;

   logic           sym_tick;
   logic           period_tick;
   logic           slotted;
   logic           skip_ca;
   logic           ble;
   logic [2:0]     minbe;
   logic [2:0]     maxbf;
   logic [2:0]     be_init;
   logic [1:0]     cw_init;
   logic           boundary;
   logic [3:0]     rf_stab;
   logic [6:0]     short_len;
   logic [6:0]     long_len;
   logic [6:0]     ifs_len;
   logic [6:0]     turn_len;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   csma_period_timer #(
      .CYCLES_PER_SYMBOL  (CYCLES_PER_SYMBOL),
      .SYMBOLS_PER_PERIOD (SYMBOLS_PER_PERIOD)
   ) u_timer (
      .clk_in          (CLOCK_IN),
      .reset_n_in      (RESET_N_IN),
      .ce_in           (CE_IN),
      .sym_tick_out    (sym_tick),
      .period_tick_out (period_tick)
   );

   assign slotted   = mac_ctl_reg[`CSMA_SLOTTED_BIT];
   assign skip_ca   = mac_ctl_reg[`CSMA_SKIP_CA_BIT];
   assign ble       = mac_ctl_reg[`CSMA_BLE_BIT];
   assign minbe     = {1'b0, mac_ctl_reg[`CSMA_MINBE_HI:`CSMA_MINBE_LO]};
   assign maxbf     = mac_ctl_reg[`CSMA_MAXBF_HI:`CSMA_MAXBF_LO];
   // Battery life extension caps the exponent so the radio listens for fewer periods.
   assign be_init   = (slotted && ble && minbe > `CSMA_BLE_MAX_BE) ? `CSMA_BLE_MAX_BE : minbe;
   assign cw_init   = slotted ? `CSMA_SLOTTED_CW : `CSMA_UNSLOTTED_CW;
   assign boundary  = slotted ? SLOT_BOUNDARY_IN : period_tick;
   assign rf_stab   = stab_reg[`CSMA_RF_STAB_HI:`CSMA_RF_STAB_LO];
   assign short_len = csma_sum({2'h0, stab_reg[`CSMA_SHORT_HI:`CSMA_SHORT_LO]}, rf_stab);
   assign long_len  = csma_sum(long_sp_reg[`CSMA_LONG_HI:`CSMA_LONG_LO], rf_stab);
   assign turn_len  = csma_sum({2'h0, turn_reg}, rf_stab);
   assign ifs_len   = (len_reg > `CSMA_SIFS_MAX_OCTETS) ? long_len : short_len;
   assign wr_maxbf  = (WR_DATA_IN[`CSMA_MAXBF_HI:`CSMA_MAXBF_LO] > `CSMA_MAXBF_LIMIT) ?
                      `CSMA_MAXBF_LIMIT : WR_DATA_IN[`CSMA_MAXBF_HI:`CSMA_MAXBF_LO];

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Register file and status flags; a hardware set beats a same-cycle clear.
   always_comb begin
      mac_ctl_next = mac_ctl_reg;
      long_sp_next = long_sp_reg;
      turn_next    = turn_reg;
      stab_next    = stab_reg;
      fail_st_next = fail_st_reg;
      done_st_next = done_st_reg;
      rd_next      = 8'h00;
      if (WR_STROBE_IN) begin
         case (ADDR_IN)
            `CSMA_ADDR_MAC_CTL: mac_ctl_next = {WR_DATA_IN[7:3], wr_maxbf};
            `CSMA_ADDR_LONG_SP: long_sp_next = WR_DATA_IN;
            `CSMA_ADDR_TURN:    turn_next    = WR_DATA_IN[`CSMA_TURN_HI:`CSMA_TURN_LO];
            `CSMA_ADDR_STAB:    stab_next    = WR_DATA_IN;
            `CSMA_ADDR_STATUS: begin
               fail_st_next = fail_st_reg & ~WR_DATA_IN[`CSMA_ST_FAIL_BIT];
               done_st_next = done_st_reg & ~WR_DATA_IN[`CSMA_ST_DONE_BIT];
            end
            default: ;
         endcase
      end
      if (fail_next) begin
         fail_st_next = 1'b1;
      end
      if (done_next) begin
         done_st_next = 1'b1;
      end
      if (RD_STROBE_IN) begin
         case (ADDR_IN)
            `CSMA_ADDR_MAC_CTL: rd_next = mac_ctl_reg;
            `CSMA_ADDR_LONG_SP: rd_next = long_sp_reg;
            `CSMA_ADDR_TURN:    rd_next = {turn_reg, 4'h0};
            `CSMA_ADDR_STAB:    rd_next = stab_reg;
            `CSMA_ADDR_STATUS: rd_next = {BUSY_OUT, 5'h00, done_st_reg, fail_st_reg};
            default:           rd_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         mac_ctl_reg <= `CSMA_MAC_CTL_RST;
         long_sp_reg <= `CSMA_LONG_SP_RST;
         turn_reg    <= 4'(`CSMA_TURN_RST >> `CSMA_TURN_LO);
         stab_reg    <= `CSMA_STAB_RST;
         fail_st_reg <= 1'b0;
         done_st_reg <= 1'b0;
         RD_DATA_OUT <= 8'h00;
      end else if (CE_IN) begin
         mac_ctl_reg <= mac_ctl_next;
         long_sp_reg <= long_sp_next;
         turn_reg    <= turn_next;
         stab_reg    <= stab_next;
         fail_st_reg <= fail_st_next;
         done_st_reg <= done_st_next;
         RD_DATA_OUT <= rd_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Channel access sequencer. Requests are taken only in idle, so spacing cannot be cut short.
   always_comb begin
      state_next   = state_reg;
      nb_next      = nb_reg;
      be_next      = be_reg;
      cw_next      = cw_reg;
      cnt_next     = cnt_reg;
      sym_cnt_next = sym_cnt_reg;
      len_next     = len_reg;
      ack_next     = ack_reg;
      start_next   = 1'b0;
      fail_next    = 1'b0;
      done_next    = 1'b0;
      lfsr_next    = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
      case (state_reg)
         CSMA_ST_IDLE: begin
            if (TX_REQ_IN) begin
               len_next = TX_LEN_IN;
               ack_next = TX_ACK_REQ_IN;
               if (skip_ca) begin
                  state_next = CSMA_ST_TX;
                  start_next = 1'b1;
               end else begin
                  nb_next    = 3'h0;
                  be_next    = be_init;
                  cw_next    = cw_init;
                  cnt_next   = lfsr_reg[4:0] & csma_mask(be_init);
                  state_next = CSMA_ST_BACKOFF;
               end
            end
         end
         CSMA_ST_BACKOFF: begin
            if (boundary) begin
               if (cnt_reg != 5'h00) begin
                  cnt_next = cnt_reg - 5'h01;
               end else if (CCA_CLEAR_IN) begin
                  if (cw_reg == 2'h1) begin
                     state_next   = CSMA_ST_TURN;
                     sym_cnt_next = turn_len;
                  end else begin
                     cw_next = cw_reg - 2'h1;
                  end
               end else if (nb_reg >= maxbf) begin
                  state_next = CSMA_ST_IDLE;
                  fail_next  = 1'b1;
               end else begin
                  nb_next  = nb_reg + 3'h1;
                  be_next  = (be_reg >= `CSMA_MAX_BE) ? `CSMA_MAX_BE : be_reg + 3'h1;
                  cw_next  = cw_init;
                  cnt_next = lfsr_reg[4:0] & csma_mask(be_next);
               end
            end
         end
         CSMA_ST_TURN: begin
            if (sym_tick) begin
               if (sym_cnt_reg == 7'h00) begin
                  state_next = CSMA_ST_TX;
                  start_next = 1'b1;
               end else begin
                  sym_cnt_next = sym_cnt_reg - 7'h01;
               end
            end
         end
         CSMA_ST_TX: begin
            if (TX_END_IN) begin
               if (ack_reg) begin
                  state_next = CSMA_ST_ACK;
               end else begin
                  state_next   = CSMA_ST_IFS;
                  sym_cnt_next = ifs_len;
               end
            end
         end
         CSMA_ST_ACK: begin
            if (ACK_DONE_IN) begin
               state_next   = CSMA_ST_IFS;
               sym_cnt_next = ifs_len;
            end
         end
         CSMA_ST_IFS: begin
            // The first tick may come early, so one extra tick keeps the gap at or above the length.
            if (sym_tick) begin
               if (sym_cnt_reg == 7'h00) begin
                  state_next = CSMA_ST_IDLE;
                  done_next  = 1'b1;
               end else begin
                  sym_cnt_next = sym_cnt_reg - 7'h01;
               end
            end
         end
         default: state_next = CSMA_ST_IDLE;
      endcase
      busy_next = (state_next != CSMA_ST_IDLE);
   end

   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         state_reg    <= CSMA_ST_IDLE;
         nb_reg       <= 3'h0;
         be_reg       <= 3'h0;
         cw_reg       <= 2'h0;
         cnt_reg      <= 5'h00;
         sym_cnt_reg  <= 7'h00;
         len_reg      <= 7'h00;
         ack_reg      <= 1'b0;
         lfsr_reg     <= 16'hace1;
         TX_START_OUT <= 1'b0;
         CA_FAIL_OUT  <= 1'b0;
         TX_DONE_OUT  <= 1'b0;
         BUSY_OUT     <= 1'b0;
      end else if (CE_IN) begin
         state_reg    <= state_next;
         nb_reg       <= nb_next;
         be_reg       <= be_next;
         cw_reg       <= cw_next;
         cnt_reg      <= cnt_next;
         sym_cnt_reg  <= sym_cnt_next;
         len_reg      <= len_next;
         ack_reg      <= ack_next;
         lfsr_reg     <= lfsr_next;
         TX_START_OUT <= start_next;
         CA_FAIL_OUT  <= fail_next;
         TX_DONE_OUT  <= done_next;
         BUSY_OUT     <= busy_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Frozen cycles abort any attempt in flight, so the checks only judge enabled time.
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (!RESET_N_IN || !CE_IN);

   sequence s_start_csma;
      state_reg == CSMA_ST_IDLE && TX_REQ_IN && !skip_ca;
   endsequence

   sequence s_enter_turn;
      state_reg == CSMA_ST_BACKOFF ##1 state_reg == CSMA_ST_TURN;
   endsequence

   a_slot_boundary_align: assert property ((state_reg == CSMA_ST_BACKOFF && slotted && !SLOT_BOUNDARY_IN) |=>
      state_reg == CSMA_ST_BACKOFF && $stable(cnt_reg))
      else $error("Slotted backoff moved off a slot boundary.");

   a_unslotted_local_grid: assert property ((state_reg == CSMA_ST_BACKOFF && !slotted && !period_tick) |=>
      state_reg == CSMA_ST_BACKOFF && $stable(cnt_reg))
      else $error("Unslotted backoff moved off the local period grid.");

   a_mode_window_select: assert property (s_start_csma |=>
      cw_reg == ($past(slotted) ? `CSMA_SLOTTED_CW : `CSMA_UNSLOTTED_CW))
      else $error("Contention window does not match access mode.");

   a_ble_exponent_cap: assert property ((s_start_csma and (slotted && ble)) |=> be_reg <= `CSMA_BLE_MAX_BE)
      else $error("Battery life extension did not cap the exponent.");

   a_min_exponent_seed: assert property ((s_start_csma and !(slotted && ble)) |=> be_reg == $past(minbe))
      else $error("Backoff exponent not seeded from minimum field.");

   a_fail_after_limit: assert property (CA_FAIL_OUT |-> $past(nb_reg) >= $past(maxbf)
      && state_reg == CSMA_ST_IDLE && fail_st_reg && !TX_START_OUT)
      else $error("Channel access failure reported before the limit.");

   a_spacing_length: assert property ((state_reg != CSMA_ST_IFS) ##1 (state_reg == CSMA_ST_IFS) |->
      sym_cnt_reg == $past(ifs_len))
      else $error("Interframe spacing loaded with the wrong length.");

   a_spacing_after_ack: assert property ((state_reg == CSMA_ST_TX && TX_END_IN && ack_reg) |=>
      state_reg == CSMA_ST_ACK ##1 (state_reg != CSMA_ST_IFS || $past(ACK_DONE_IN)))
      else $error("Spacing started before the acknowledgment.");

   a_turnaround_length: assert property (s_enter_turn |-> sym_cnt_reg == $past(turn_len))
      else $error("Turnaround loaded with the wrong length.");

   a_no_csma_direct: assert property ((state_reg == CSMA_ST_IDLE && TX_REQ_IN && skip_ca) |=>
      TX_START_OUT && state_reg == CSMA_ST_TX)
      else $error("No-CSMA request did not start at once.");

endmodule : csma_ifs_top

// file: testbench/csma_radio_model.sv
module csma_radio_model #(
   parameter int TX_CYCLES   = 20,
   parameter int ACK_CYCLES  = 30,
   parameter int SLOT_CYCLES = 8
) (
   input  wire logic clk_in,
   input  wire logic reset_n_in,
   input  wire logic tx_start_in,
   input  wire logic ack_req_in,
   input  wire logic channel_busy_in,
   output logic      cca_clear_out,
   output logic      slot_boundary_out,
   output logic      tx_end_out,
   output logic      ack_done_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int   air_count;
   int   slot_count;
   logic want_ack;
   logic on_air;
   ////////////////////////////////////////////////////////////////
   // The channel answers at once; peers are not modelled beyond a busy level.
   assign cca_clear_out = !channel_busy_in;
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         {slot_boundary_out, tx_end_out, ack_done_out, want_ack, on_air} <= '0;
         {air_count, slot_count} <= '0;
      end else begin
         slot_count        <= (slot_count == SLOT_CYCLES - 1) ? 0 : slot_count + 1;
         slot_boundary_out <= (slot_count == SLOT_CYCLES - 1);
         tx_end_out        <= on_air && air_count == TX_CYCLES;
         ack_done_out      <= on_air && want_ack && air_count == TX_CYCLES + ACK_CYCLES;
         if (tx_start_in) begin
            {on_air, want_ack, air_count} <= {1'b1, ack_req_in, 32'd0};
         end else if (on_air) begin
            air_count <= air_count + 1;
            on_air    <= air_count < TX_CYCLES + ACK_CYCLES;
         end
      end
   end
endmodule : csma_radio_model

// file: testbench/testbench.sv
`include "csma_defs.svh"
`define CHECK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
   $display("BAD %s expected %h seen %h", nm, exp, got); end end

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CPS = 4;
   logic       clock = 0, reset_n = 0, wr_stb = 0, rd_stb = 0, tx_req = 0, ack_req = 0, busy_ch = 0;
   logic [9:0] addr = '0;
   logic [7:0] wdata = '0, rdata, pend = 8'h84, stab = 8'h75, turn = 8'h50, ctl = 8'h1c;
   logic [6:0] tx_len = '0;
   logic       cca, slot, tx_end, ack_done, tx_start, busy, ca_fail, tx_done;
   int         bad_count = 0, samples_checked = 0;
   logic [9:0] addrs[5] = '{10'h011, 10'h021, 10'h027, 10'h02e, 10'h100};
   logic [7:0] rstv[5]  = '{8'h1c, 8'h84, 8'h50, 8'h75, 8'h00};
   logic [7:0] ctls[4]  = '{8'h00, 8'h1c, 8'h7b, 8'h2d};
   always #5 clock = ~clock;
   csma_ifs_top #(.CYCLES_PER_SYMBOL(CPS), .SYMBOLS_PER_PERIOD(2)) DUT (.CLOCK_IN(clock), .RESET_N_IN(reset_n),
      .CE_IN(1'b1), .ADDR_IN(addr), .WR_DATA_IN(wdata), .WR_STROBE_IN(wr_stb), .RD_STROBE_IN(rd_stb),
      .RD_DATA_OUT(rdata), .TX_REQ_IN(tx_req), .TX_LEN_IN(tx_len), .TX_ACK_REQ_IN(ack_req),
      .CCA_CLEAR_IN(cca), .SLOT_BOUNDARY_IN(slot), .TX_END_IN(tx_end), .ACK_DONE_IN(ack_done),
      .TX_START_OUT(tx_start), .BUSY_OUT(busy), .CA_FAIL_OUT(ca_fail), .TX_DONE_OUT(tx_done));
   csma_radio_model radio (.clk_in(clock), .reset_n_in(reset_n), .tx_start_in(tx_start), .ack_req_in(ack_req),
      .channel_busy_in(busy_ch), .cca_clear_out(cca), .slot_boundary_out(slot), .tx_end_out(tx_end),
      .ack_done_out(ack_done));
   ////////////////////////////////////////////////////////////////
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : stop_test
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge clock);
      {addr, wdata, wr_stb} <= {a, d, 1'b1};
      @(posedge clock);
      wr_stb <= 1'b0;
      if (a == 10'h021) pend = d;
      if (a == 10'h02e) stab = d;
      if (a == 10'h011) ctl = d;
   endtask : wr
   task automatic rd(input logic [9:0] a, input logic [7:0] exp);
      @(posedge clock);
      {addr, rd_stb} <= {a, 1'b1};
      @(posedge clock);
      rd_stb <= 1'b0;
      #1 `CHECK("read_data", exp, rdata)
   endtask : rd
   // Spacing exits on a symbol tick, so up to two symbols of slack are allowed.
   task automatic send(input logic [6:0] len, input logic ack, input logic fail_exp);
      int n;
      int mark;
      int first;
      int sym;
      sym = (len > 7'h12) ? pend[7:2] + stab[7:4] : stab[3:0] + stab[7:4];
      {n, mark, first} = '0;
      @(posedge clock);
      {tx_req, tx_len, ack_req} <= {1'b1, len, ack};
      @(posedge clock);
      tx_req <= 1'b0;
      #1 if (ctl[7]) `CHECK("start_next", 1'b1, tx_start)
      while (tx_done !== 1'b1 && ca_fail !== 1'b1 && n < 30000) begin
         @(posedge clock);
         #1 n++;
         if (tx_start === 1'b1 && first == 0) first = n;
         if ((ack ? ack_done : tx_end) === 1'b1) mark = n;
      end
      if (n >= 30000) begin
         bad_count++;
         stop_test();
      end
      `CHECK("ca_fail", fail_exp, ca_fail)
      if (!fail_exp) begin
         `CHECK("started", 1'b1, ctl[7] || first > 0)
         `CHECK("spacing", 1'b1, mark > 0 && n - mark >= sym * CPS && n - mark <= (sym + 2) * CPS)
         `CHECK("busy_end", 1'b0, busy)
         if (!ctl[7]) `CHECK("turnaround", 1'b1, first >= (turn[7:4] + stab[7:4]) * CPS)
      end
      $display("test frame len %0d ack %0d done", len, ack);
   endtask : send
   ////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h59af));
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      foreach (addrs[i]) rd(addrs[i], rstv[i]);
      wr(10'h011, 8'h0f);
      rd(10'h011, 8'h0d);
      wr(10'h011, 8'h80);
      for (int i = 0; i < 8; i++) begin
         wr(10'h02e, {4'($urandom % 3 + 1), 4'($urandom % 4 + 1)});
         wr(10'h021, {6'($urandom % 16 + 1), 2'b00});
         send(i == 0 ? 7'h12 : i == 1 ? 7'h13 : 7'($urandom % 127 + 1), 1'($urandom), 1'b0);
      end
      foreach (ctls[i]) begin
         wr(10'h011, ctls[i]);
         send(7'($urandom % 127 + 1), 1'($urandom), 1'b0);
      end
      busy_ch <= 1'b1;
      wr(10'h011, 8'h02);
      send(7'h0a, 1'b0, 1'b1);
      wr(10'h011, 8'h20);
      send(7'h0a, 1'b0, 1'b1);
      rd(10'h03f, 8'h03);
      wr(10'h03f, 8'h03);
      rd(10'h03f, 8'h00);
      stop_test();
   end
endmodule : testbench
